// >>> rtl/bfp_params.svh
// Constants for the bridge fault protection block
`ifndef BFP_PARAMS_SVH
`define BFP_PARAMS_SVH
`define BFP_ADDR_CONF      8'h00
`define BFP_ADDR_STATUS    8'h04
`define BFP_ADDR_IRQ_STAT  8'h08
`define BFP_ADDR_IRQ_MASK  8'h0C
`define BFP_ADDR_CTRL      8'h10
`define BFP_CLK_MHZ        100
`define BFP_FILT0_NS       100
`define BFP_FILT1_NS       1000
`define BFP_FILT2_NS       2000
`define BFP_FILT3_NS       3000
`define BFP_DLY0_NS        750
`define BFP_DLY1_NS        1500
`define BFP_CYC(ns)        (((ns) * `BFP_CLK_MHZ + 999) / 1000)
`define BFP_LS_LVL_MIN     4'h4
`define BFP_HS_LVL_MIN     4'h2
`define BFP_LS_LVL_OTP0    4'h6
`define BFP_LS_LVL_OTP1    4'hC
`define BFP_HS_LVL_RST     4'hC
`define BFP_FILT_RST       2'h1
`define BFP_RETRY_RST      2'h3
`define BFP_TEMP_PREWARN   2'h1
`define BFP_TEMP_136       2'h2
`define BFP_TEMP_143       2'h3
`define BFP_TSEL_RST       2'h0
`define BFP_IRQ_W          4
`endif

// >>> rtl/bfp_pkg.sv
// Types for the bridge fault protection block
package bfp_pkg;
	typedef enum logic [3:0] {
		BFP_IDLE  = 4'b0001,
		BFP_DELAY = 4'b0010,
		BFP_WATCH = 4'b0100,
		BFP_TRIP  = 4'b1000
	} bfp_state_t;
endpackage : bfp_pkg

// >>> rtl/bfp_top.sv
// Bridge short and overtemperature protection with AXI4-Lite registers
// Contract
// R1 - Temperature code is compared to a fixed 120 C prewarn and a selectable 136/143/150 C limit; here tsel_reg 1, 2 and 3 all trip at 143 C.
// R2 - After overtemperature shutdown the driver stays off until temperature drops below prewarn.
// R3 - Shorts are detected per half bridge from high-side and low-side voltage drop comparators.
// R4 - Low-side short level field spans 4 to 15 and resets to 6 or 12 per OTP strap.
// R5 - High-side short level field spans 2 to 15, 2 most sensitive.
// R6 - A two-bit filter selects 100 ns, 1 us (default), 2 us or 3 us short spike filtering.
// R7 - Up to 0..3 retries (default 3) precede permanent bridge shutdown.
// R8 - Detection delay bit selects 750 ns (0) or 1500 ns (1) after switch-on.
// R9 - Supply-short disable bit at 1 ignores supply-short detection.
// R10 - Ground-short disable bit at 1 ignores ground-short detection.
// R11 - Parallel-protect bit 0 shuts only the faulty bridge, 1 (default) shuts all bridges.
// R12 - A confirmed short shuts off its bridge and sets that phase's ground or supply flag.
// R13 - The host disables then re-enables the driver to resume after a short shutdown.
// R14 - With direct indication set every overcurrent pulse shows at once on the fault pin; the code shows only filtered trips (trip_ev).
// R15 - Disabling the driver clears retry counters and the latched short state.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`include "bfp_params.svh"
module bfp_top
	import bfp_pkg::*;
#(
	parameter int RETRY_W = 2
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        otp_ls_level_sel,
	input  wire logic [1:0]  temp_level,
	input  wire logic [2:0]  hs_drop,
	input  wire logic [2:0]  ls_drop,
	input  wire logic [2:0]  bridge_on,
	output logic [5:0]       short_level_out,
	output logic [2:0]       bridge_enable,
	output logic             fault,
	output logic             irq
);
	// Async pin inputs through three flops; accept change when stages 2 and 3 agree
	logic [10:0] s1_reg, s2_reg, s3_reg, in_reg;
	wire  [10:0] pins_raw = {temp_level, hs_drop, ls_drop, bridge_on};
	always_ff @(posedge aclk) begin
		s1_reg <= pins_raw;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end
	wire [10:0] in_next = (s2_reg & s3_reg) | (in_reg & (s2_reg | s3_reg));
	always_ff @(posedge aclk) begin
		if (!aresetn) in_reg <= '0;
		else in_reg <= in_next;
	end
	wire [1:0] temp_s   = in_reg[10:9];
	wire [2:0] hs_s     = in_reg[8:6];
	wire [2:0] ls_s     = in_reg[5:3];
	wire [2:0] bron_s   = in_reg[2:0];

	// Configuration
	logic [3:0] ls_lvl_reg, hs_lvl_reg;
	logic [1:0] filt_reg, retry_reg, tsel_reg;
	logic dly_reg, s2vs_off_reg, s2g_off_reg, par_reg, direct_reg, drv_en_reg;
	logic [`BFP_IRQ_W-1:0] ist_reg, imask_reg;
	logic strap_done_reg;

	// AXI write path: address and data accepted independently
	logic aw_full_reg, w_full_reg;
	logic [7:0] aw_reg;
	logic [31:0] wd_reg;
	logic [3:0] ws_reg;
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
	wire  do_wr  = aw_full_reg && w_full_reg && !s_axi_bvalid;
	wire  wr_cf  = do_wr && aw_reg == `BFP_ADDR_CONF && ws_reg[1:0] == 2'h3;
	wire  wr_ist = do_wr && aw_reg == `BFP_ADDR_IRQ_STAT && ws_reg[0];
	wire  wr_im  = do_wr && aw_reg == `BFP_ADDR_IRQ_MASK && ws_reg[0];
	wire  wr_ct  = do_wr && aw_reg == `BFP_ADDR_CTRL && ws_reg[0];
	wire  wr_ok  = aw_reg == `BFP_ADDR_CONF || aw_reg == `BFP_ADDR_STATUS ||
		aw_reg == `BFP_ADDR_IRQ_STAT || aw_reg == `BFP_ADDR_IRQ_MASK ||
		aw_reg == `BFP_ADDR_CTRL;
	wire [3:0] ls_w = (wd_reg[3:0] < `BFP_LS_LVL_MIN) ? `BFP_LS_LVL_MIN : wd_reg[3:0];
	wire [3:0] hs_w = (wd_reg[7:4] < `BFP_HS_LVL_MIN) ? `BFP_HS_LVL_MIN : wd_reg[7:4];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_reg      <= 8'h00;
			wd_reg      <= 32'h00000000;
			ws_reg      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_reg      <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				wd_reg     <= s_axi_wdata;
				ws_reg     <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
		end
	end

	// Registers; low-side default caught from the strap at reset release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ls_lvl_reg <= `BFP_LS_LVL_OTP0;
			strap_done_reg <= 1'b0;
			hs_lvl_reg <= `BFP_HS_LVL_RST;
			filt_reg <= `BFP_FILT_RST; // R6
			retry_reg <= `BFP_RETRY_RST; // R7
			dly_reg <= 1'b0;
			s2vs_off_reg <= 1'b0;
			s2g_off_reg <= 1'b0;
			par_reg <= 1'b1; // R11
			direct_reg <= 1'b0;
			tsel_reg <= `BFP_TSEL_RST;
			imask_reg <= '0;
			drv_en_reg <= 1'b0;
		end else begin
			strap_done_reg <= 1'b1;
			if (!strap_done_reg)
				ls_lvl_reg <= otp_ls_level_sel ? `BFP_LS_LVL_OTP1 : `BFP_LS_LVL_OTP0; // R4
			else if (wr_cf) ls_lvl_reg <= ls_w; // R4
			if (wr_cf) begin
				hs_lvl_reg <= hs_w; // R5
				filt_reg <= wd_reg[9:8];
				retry_reg <= wd_reg[11:10];
				dly_reg <= wd_reg[12];
				s2vs_off_reg <= wd_reg[13];
				s2g_off_reg <= wd_reg[14];
				par_reg <= wd_reg[15];
			end
			if (wr_im) imask_reg <= wd_reg[`BFP_IRQ_W-1:0];
			if (wr_ct) begin
				drv_en_reg <= wd_reg[0];
				direct_reg <= wd_reg[1];
				tsel_reg <= wd_reg[3:2];
			end
		end
	end
	assign short_level_out = {hs_lvl_reg[3:1], ls_lvl_reg[3:1]};

	// Temperature: shutdown latched until below prewarn
	wire [1:0] tsd_code = (tsel_reg == 2'h0) ? `BFP_TEMP_136 :
		(tsel_reg == 2'h1) ? `BFP_TEMP_143 : 2'h3;
	wire tsd_hit  = (tsel_reg == 2'h2) ? (temp_s == 2'h3 && tsel_reg[1]) :
		(temp_s >= tsd_code); // R1
	wire prewarn  = temp_s >= `BFP_TEMP_PREWARN; // R1
	logic ot_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) ot_reg <= 1'b0;
		else if (tsd_hit) ot_reg <= 1'b1;
		else if (!prewarn) ot_reg <= 1'b0; // R2
	end

	// Timing counts
	localparam int FC0 = `BFP_CYC(`BFP_FILT0_NS);
	localparam int FC1 = `BFP_CYC(`BFP_FILT1_NS);
	localparam int FC2 = `BFP_CYC(`BFP_FILT2_NS);
	localparam int FC3 = `BFP_CYC(`BFP_FILT3_NS);
	localparam int DC0 = `BFP_CYC(`BFP_DLY0_NS);
	localparam int DC1 = `BFP_CYC(`BFP_DLY1_NS);
	wire [8:0] filt_cyc = (filt_reg == 2'h0) ? 9'(FC0) : (filt_reg == 2'h1) ? 9'(FC1) :
		(filt_reg == 2'h2) ? 9'(FC2) : 9'(FC3); // R6
	wire [8:0] dly_cyc = dly_reg ? 9'(DC1) : 9'(DC0); // R8

	// Per-phase short detector
	logic [2:0] gnd_flag_reg, sup_flag_reg, off_reg;
	bfp_state_t st_reg [3];
	logic [8:0] cnt_reg [3];
	logic [RETRY_W-1:0] rt_reg [3];
	logic drv_en_d_reg;
	wire drv_cycle = drv_en_d_reg && !drv_en_reg; // R15
	wire [2:0] g_raw = hs_s & {3{!s2g_off_reg}}; // R3 R10
	wire [2:0] v_raw = ls_s & {3{!s2vs_off_reg}}; // R3 R9
	wire [2:0] trip_ev, g_ev, v_ev;
	always_ff @(posedge aclk) begin
		if (!aresetn) drv_en_d_reg <= 1'b0;
		else drv_en_d_reg <= drv_en_reg;
	end
	for (genvar p = 0; p < 3; p++) begin : g_ph
		wire any = g_raw[p] | v_raw[p];
		wire filt_done = cnt_reg[p] >= filt_cyc - 9'h001;
		wire last = rt_reg[p] >= RETRY_W'(retry_reg);
		assign trip_ev[p] = st_reg[p] == BFP_WATCH && any && filt_done;
		assign g_ev[p] = trip_ev[p] && last && g_raw[p];
		assign v_ev[p] = trip_ev[p] && last && v_raw[p];
		always_ff @(posedge aclk) begin
			if (!aresetn || drv_cycle) begin
				st_reg[p] <= BFP_IDLE;
				cnt_reg[p] <= 9'h000;
				rt_reg[p] <= '0; // R15
				off_reg[p] <= 1'b0; // R15
				gnd_flag_reg[p] <= 1'b0;
				sup_flag_reg[p] <= 1'b0;
			end else begin
				case (st_reg[p])
					BFP_IDLE: begin
						cnt_reg[p] <= 9'h000;
						if (bron_s[p] && !off_reg[p]) st_reg[p] <= BFP_DELAY;
					end
					BFP_DELAY: begin
						cnt_reg[p] <= cnt_reg[p] + 9'h001;
						if (!bron_s[p]) st_reg[p] <= BFP_IDLE;
						else if (cnt_reg[p] >= dly_cyc - 9'h001) begin // R8
							st_reg[p] <= BFP_WATCH;
							cnt_reg[p] <= 9'h000;
						end
					end
					BFP_WATCH: begin
						cnt_reg[p] <= any ? cnt_reg[p] + 9'h001 : 9'h000; // R6
						if (trip_ev[p]) begin
							st_reg[p] <= BFP_TRIP;
							if (last) begin
								off_reg[p] <= 1'b1; // R7 R12
								gnd_flag_reg[p] <= gnd_flag_reg[p] | g_raw[p]; // R12
								sup_flag_reg[p] <= sup_flag_reg[p] | v_raw[p]; // R12
							end else rt_reg[p] <= rt_reg[p] + RETRY_W'(1); // R7
						end else if (!bron_s[p]) st_reg[p] <= BFP_IDLE;
					end
					BFP_TRIP: begin
						cnt_reg[p] <= 9'h000;
						if (!bron_s[p]) st_reg[p] <= BFP_IDLE;
					end
					default: st_reg[p] <= BFP_IDLE;
				endcase
			end
		end
	end

	// Bridge enables: retry shuts the bridge for the rest of the on-phase
	wire [2:0] ph_block;
	for (genvar q = 0; q < 3; q++) begin : g_blk
		assign ph_block[q] = off_reg[q] || st_reg[q] == BFP_TRIP;
	end
	wire any_off = |off_reg;
	wire [2:0] en_next = {3{drv_en_reg && !ot_reg}} & // R2
		~(par_reg ? {3{any_off}} | ph_block : ph_block); // R11 R12
	wire fault_next = any_off || ot_reg || (direct_reg && (|trip_ev)); // R14
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bridge_enable <= 3'h0;
			fault <= 1'b0;
		end else begin
			bridge_enable <= en_next;
			fault <= fault_next;
		end
	end

	// Sticky events: ground short, supply short, prewarn, shutdown; set wins over clear
	wire [`BFP_IRQ_W-1:0] ev = {tsd_hit, prewarn, |v_ev, |g_ev};
	wire [`BFP_IRQ_W-1:0] clr = wr_ist ? wd_reg[`BFP_IRQ_W-1:0] : '0;
	always_ff @(posedge aclk) begin
		if (!aresetn) ist_reg <= '0;
		else ist_reg <= (ist_reg & ~clr) | ev;
	end
	assign irq = |(ist_reg & imask_reg);

	// Read path
	wire [31:0] conf_rd = {16'h0000, par_reg, s2g_off_reg, s2vs_off_reg, dly_reg,
		retry_reg, filt_reg, hs_lvl_reg, ls_lvl_reg};
	wire [31:0] stat_rd = {21'h000000, bridge_enable, ot_reg, prewarn,
		sup_flag_reg, gnd_flag_reg};
	wire [31:0] ctrl_rd = {28'h0000000, tsel_reg, direct_reg, drv_en_reg};
	wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
	wire rd_ok = ra == `BFP_ADDR_CONF || ra == `BFP_ADDR_STATUS ||
		ra == `BFP_ADDR_IRQ_STAT || ra == `BFP_ADDR_IRQ_MASK || ra == `BFP_ADDR_CTRL;
	wire [31:0] rd_mux = (ra == `BFP_ADDR_CONF) ? conf_rd :
		(ra == `BFP_ADDR_STATUS) ? stat_rd :
		(ra == `BFP_ADDR_IRQ_STAT) ? {28'h0000000, ist_reg} :
		(ra == `BFP_ADDR_IRQ_MASK) ? {28'h0000000, imask_reg} :
		(ra == `BFP_ADDR_CTRL) ? ctrl_rd : 32'h00000000;
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
	end
endmodule : bfp_top

// >>> sim/bfp_top_monitor.sv
// Checker for the bridge fault protection ports
module bfp_top_monitor
	import bfp_pkg::*;
#(
	parameter int RETRY_W = 2
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  temp_level,
	input wire logic [5:0]  short_level_out,
	input wire logic [2:0]  bridge_enable,
	input wire logic        fault
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Eight cycles covers the sensor synchroniser
	sequence s_hot;
		temp_level == 2'h3 [*8];
	endsequence
	property p_rst_out;
		$rose(aresetn) |-> bridge_enable == 3'h0 && !fault && !s_axi_bvalid;
	endproperty
	property p_overtemp_off;
		s_hot |-> ##[0:6] (bridge_enable == 3'h0 && fault);
	endproperty
	property p_stay_off;
		s_hot ##1 (temp_level == 2'h1) [*8] |-> bridge_enable == 3'h0;
	endproperty
	property p_level_range;
		aresetn [*4] |-> short_level_out[5:3] >= 3'h1 && short_level_out[2:0] >= 3'h2;
	endproperty
	property p_bvalid_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_rvalid_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_rd_answer;
		s_ar_taken |=> s_axi_rvalid;
	endproperty
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs active after reset");
	a_overtemp_off: assert property (p_overtemp_off)
		else $error("no shutdown when hot");
	a_stay_off: assert property (p_stay_off)
		else $error("bridges back above prewarn");
	a_level_range: assert property (p_level_range)
		else $error("short level below minimum");
	a_bvalid_hold: assert property (p_bvalid_hold)
		else $error("write response dropped");
	a_rvalid_hold: assert property (p_rvalid_hold)
		else $error("read data dropped");
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late");
	a_aw_block: assert property (p_aw_block)
		else $error("address taken while response pending");
endmodule : bfp_top_monitor

// >>> sim/bfp_bridge_model.sv
// External half-bridge model, drop seen only while conducting into a short
module bfp_bridge_model (
	input  wire logic [2:0] bridge_on,
	input  wire logic [2:0] bridge_enable,
	input  wire logic [2:0] gnd_short,
	input  wire logic [2:0] sup_short,
	output logic [2:0]      hs_drop,
	output logic [2:0]      ls_drop
);
	timeunit 1ns;
	timeprecision 1ps;
	assign hs_drop = bridge_on & bridge_enable & gnd_short;
	assign ls_drop = bridge_on & bridge_enable & sup_short;
endmodule : bfp_bridge_model

// >>> sim/bfp_top_test.sv
// Self-checking bench for the bridge fault protection block
`include "bfp_params.svh"
module bfp_top_test;
	import bfp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, fault, irq, otp_sel, f_seen;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
	logic [1:0]  s_axi_bresp, s_axi_rresp, temp_level, rd_resp, wr_resp;
	logic [3:0]  s_axi_wstrb;
	logic [2:0]  hs_drop, ls_drop, bridge_on, bridge_enable, gnd_short, sup_short;
	logic [5:0]  short_level_out;
	int          bad_count, check_count, seed, conf_m, rv, n_w;
	bfp_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.otp_ls_level_sel(otp_sel), .temp_level, .hs_drop, .ls_drop, .bridge_on,
		.short_level_out, .bridge_enable, .fault, .irq);
	bfp_bridge_model u_brg (.bridge_on, .bridge_enable, .gnd_short, .sup_short,
		.hs_drop, .ls_drop);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (n < 200) begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				wr_resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				n = 999;
			end
		end
		chk(n, 32'h000003E7);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (n < 200) begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd_val = s_axi_rdata;
				rd_resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				n = 999;
			end
		end
		chk(n, 32'h000003E7);
	endtask : rd
	task automatic wait_be(input logic [2:0] e, input int lim);
		int n;
		n = 0;
		while (bridge_enable !== e && n < lim) begin
			@(posedge aclk);
			n++;
		end
		chk({29'h0, bridge_enable}, {29'h0, e});
	endtask : wait_be
	// Restart the driver, since latched shorts only clear this way
	task automatic restart(input logic [31:0] c);
		wr(`BFP_ADDR_CTRL, 32'h0);
		wr(`BFP_ADDR_CTRL, c);
		bridge_on <= 3'h0;
		repeat (4) @(posedge aclk);
		bridge_on <= 3'h7;
	endtask : restart
	function automatic int clamp(input int d);
		int r;
		r = d & 32'h0000FFFF;
		if (r[3:0] < 4'h4) r[3:0] = 4'h4;
		if (r[7:4] < 4'h2) r[7:4] = 4'h2;
		return r;
	endfunction : clamp
	task automatic results();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		results();
	end
	initial begin
		seed = 32'h314EB91D;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
		{temp_level, bridge_on, gnd_short, sup_short} <= 11'h0;
		otp_sel <= 1'b0;
		s_axi_wstrb <= 4'hF;
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`BFP_ADDR_CONF);
		chk(rd_val, 32'h00008DC6);
		chk({26'h0, short_level_out}, 32'h33);
		rd(8'h20);
		chk({30'h0, rd_resp}, 32'h2);
		wr(8'h24, 32'h0);
		chk({30'h0, wr_resp}, 32'h2);
		for (int i = 0; i < 4; i++) begin
			rv = $random(seed) & 32'h0000FFFF;
			conf_m = clamp(rv);
			wr(`BFP_ADDR_CONF, rv);
			rd(`BFP_ADDR_CONF);
			chk(rd_val, conf_m);
			chk({26'h0, short_level_out}, {26'h0, conf_m[7:5], conf_m[3:1]});
		end
		wr(`BFP_ADDR_IRQ_MASK, 32'hF);
		chk({30'h0, wr_resp}, 32'h0);
		wr(`BFP_ADDR_CONF, 32'h88);
		restart(32'h1);
		wait_be(3'h7, 50);
		gnd_short <= 3'h1;
		wait_be(3'h6, 800);
		chk({31'h0, fault}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rd(`BFP_ADDR_STATUS);
		chk(rd_val, 32'h601);
		rd(`BFP_ADDR_IRQ_STAT);
		chk(rd_val, 32'h1);
		wr(`BFP_ADDR_IRQ_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		gnd_short <= 3'h0;
		restart(32'h1);
		wait_be(3'h7, 50);
		wr(`BFP_ADDR_IRQ_STAT, 32'h1);
		rd(`BFP_ADDR_IRQ_STAT);
		chk(rd_val, 32'h0);
		wr(`BFP_ADDR_CONF, 32'hC088);
		gnd_short <= 3'h2;
		restart(32'h1);
		repeat (600) @(posedge aclk);
		chk({29'h0, bridge_enable}, 32'h7);
		sup_short <= 3'h2;
		restart(32'h1);
		wait_be(3'h0, 800);
		rd(`BFP_ADDR_STATUS);
		chk(rd_val, 32'h10);
		{gnd_short, sup_short} <= 6'h0;
		restart(32'h1);
		wait_be(3'h7, 50);
		// Retry 1, 2 us filter, long delay, direct indication, phase U only
		bridge_on <= 3'h6;
		gnd_short <= 3'h1;
		wr(`BFP_ADDR_CONF, 32'h1688);
		wr(`BFP_ADDR_CTRL, 32'h0);
		wr(`BFP_ADDR_CTRL, 32'h3);
		bridge_on <= 3'h7;
		repeat (340) @(posedge aclk);
		chk({29'h0, bridge_enable}, 32'h7);
		f_seen = 1'b0;
		n_w = 0;
		while (bridge_enable === 3'h7 && n_w < 40) begin
			@(posedge aclk);
			n_w++;
			if (fault === 1'b1) f_seen = 1'b1;
		end
		chk({29'h0, bridge_enable}, 32'h6);
		chk({31'h0, f_seen}, 32'h1);
		rd(`BFP_ADDR_STATUS);
		chk(rd_val, 32'h600);
		bridge_on <= 3'h6;
		repeat (8) @(posedge aclk);
		bridge_on <= 3'h7;
		wait_be(3'h7, 20);
		wait_be(3'h6, 400);
		rd(`BFP_ADDR_STATUS);
		chk(rd_val, 32'h601);
		gnd_short <= 3'h0;
		restart(32'h1);
		wait_be(3'h7, 50);
		temp_level <= 2'h2;
		wait_be(3'h0, 50);
		rd(`BFP_ADDR_STATUS);
		chk({30'h0, rd_val[7:6]}, 32'h3);
		temp_level <= 2'h1;
		repeat (50) @(posedge aclk);
		chk({29'h0, bridge_enable}, 32'h0);
		temp_level <= 2'h0;
		wait_be(3'h7, 50);
		wr(`BFP_ADDR_CTRL, 32'h9);
		temp_level <= 2'h2;
		repeat (50) @(posedge aclk);
		chk({29'h0, bridge_enable}, 32'h7);
		temp_level <= 2'h3;
		wait_be(3'h0, 50);
		repeat (8) @(posedge aclk);
		temp_level <= 2'h1;
		repeat (50) @(posedge aclk);
		chk({29'h0, bridge_enable}, 32'h0);
		temp_level <= 2'h0;
		wait_be(3'h7, 50);
		wr(`BFP_ADDR_CTRL, 32'h5);
		temp_level <= 2'h2;
		repeat (50) @(posedge aclk);
		chk({29'h0, bridge_enable}, 32'h7);
		// Second reset with the strap high
		otp_sel <= 1'b1;
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`BFP_ADDR_CONF);
		chk(rd_val, 32'h00008DCC);
		chk({26'h0, short_level_out}, 32'h36);
		s_axi_wstrb <= 4'h1;
		wr(`BFP_ADDR_CONF, 32'h0);
		s_axi_wstrb <= 4'hF;
		rd(`BFP_ADDR_CONF);
		chk(rd_val, 32'h00008DCC);
		results();
	end
endmodule : bfp_top_test
bind bfp_top bfp_top_monitor #(.RETRY_W(RETRY_W)) u_mon (.aclk, .aresetn, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .temp_level, .short_level_out, .bridge_enable, .fault);
